// file: rtl/adc_cfg_pkg.sv
// Constants, field layouts and carrier types for the converter configuration serial port.
// Assumes a single byte-wide register space reached by 13-bit addresses.
package adc_cfg_pkg;

	// Frame geometry: 16 instruction bits, then 8-bit data words.
	localparam logic [3:0]  INSTR_LAST        = 4'hF;
	localparam logic [3:0]  BYTE_LAST         = 4'h7;
	localparam logic [3:0]  CNT_START         = 4'h0;
	localparam logic [3:0]  CNT_STEP          = 4'h1;

	// Word length code that selects an endless stream of data bytes.
	localparam logic [1:0]  WL_STREAM         = 2'h3;

	// Register addresses.
	localparam logic [12:0] ADDR_PORT_CFG     = 13'h0000;
	localparam logic [12:0] ADDR_CHIP_ID      = 13'h0001;
	localparam logic [12:0] ADDR_CHIP_GRADE   = 13'h0002;
	localparam logic [12:0] ADDR_CH_INDEX     = 13'h0005;
	localparam logic [12:0] ADDR_SHADOW_FIRST = 13'h0008;
	localparam logic [12:0] ADDR_SHADOW_LAST  = 13'h003A;
	localparam logic [12:0] ADDR_TRANSFER     = 13'h00FF;
	localparam logic [12:0] ADDR_STEP         = 13'h0001;

	// Shadowed block: entries per channel and the last valid index.
	localparam int          NUM_CH            = 2;
	localparam int          SHADOW_DEPTH      = 51;
	localparam logic [5:0]  SHADOW_LAST_IDX   = 6'h32;

	// Field layouts and reset values.
	localparam logic [7:0]  PORT_CFG_FIXED    = 8'h18;
	localparam logic [7:0]  CFG_LSB_MASK      = 8'h42;
	localparam int          CFG_LSB_HI        = 6;
	localparam int          CFG_LSB_LO        = 1;
	localparam int          CFG_RST_HI        = 5;
	localparam int          CFG_RST_LO        = 2;
	localparam int          CH_A_BIT          = 0;
	localparam logic [1:0]  CH_INDEX_RESET    = 2'h3;
	localparam logic [7:0]  TRANSFER_GO       = 8'h01;
	localparam logic [7:0]  SHADOW_RESET      = 8'h00;
	localparam logic [7:0]  BYTE_ZERO         = 8'h00;
	localparam logic [2:0]  BYTES_ONE         = 3'h1;

	// Sixteen-bit instruction as it arrives, first bit on top.
	typedef struct packed {
		logic        read;
		logic        word_length_bit1;
		logic        word_length_bit0;
		logic [12:0] addr;
	} instr_t;

	// The three serial inputs travel together through the synchroniser.
	typedef struct packed {
		logic sclk;
		logic select_n;
		logic sdio;
	} pins_t;

	localparam pins_t PINS_IDLE = '{sclk: 1'b0, select_n: 1'b1, sdio: 1'b0};

	typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_STALL, ST_DONE} frame_state_t;

endpackage : adc_cfg_pkg

// file: rtl/adc_config_serial_port.sv
// Three-wire configuration port of a dual converter: instruction decode, register space, readback.
// Assumes the serial clock is far slower than CLK_SYS, so every serial edge is seen after synchronising.
//
// What this block does; R14 is a rule for the host
// R1: Serial traffic is ignored whenever the active-low select is high.
// R2: A select falling edge restarts the instruction bit counter for a new frame.
// R3: With select held low in stream mode, data bytes continue without a new instruction.
// R4: Select high at a byte boundary mid-way through a counted transfer stalls; the next low resumes there.
// R5: Select never seen low since reset keeps the data pin released, alternate functions on.
// R6: Every frame starts with exactly sixteen instruction bits.
// R7: The two word-length bits give the number of data bytes that follow.
// R8: Data after the instruction moves in eight-bit words, one per register byte.
// R9: The first instruction bit chooses read or write for the whole frame.
// R10: On a read the data pin turns to output right after the instruction.
// R11: Bits go most significant first after reset; a config bit selects least first for the data bytes only.
// R12: Clock and select are inputs; the data pin drives only during readback.
// R13: Shifting depends only on edges of the host serial clock.
// R14: The host should keep the port idle during critical conversion intervals.
// R15: Shadowed writes take effect only when 0x01 is written to address 0xFF.
// R16: The transfer bit clears itself once the shadow update is done.
// R17: Both channel bits set: writes reach both channels, reads return channel A.
// R18: Input bits are taken on rising serial edges, output bits change on falling ones.

`timescale 1ns/100ps

module adc_config_serial_port
	import adc_cfg_pkg::*;
#(
	parameter logic [7:0] CHIP_ID_VALUE = 8'h5A, // Arbitrary identification value.
	parameter logic [1:0] SPEED_GRADE   = 2'h0
) (
	// System clock and synchronous reset.
	input  wire logic       CLK_SYS,
	input  wire logic       RESET,
	// Serial pins to and from the host.
	input  wire logic       SCLK,
	input  wire logic       PORT_SELECT_N,
	input  wire logic       SDIO_IN,
	output      logic       SDIO_OUT,
	output      logic       SDIO_OE_N,
	// Port status.
	output      logic       PORT_ALT_EN,
	output      logic       LSB_FIRST,
	output      logic [1:0] CHANNEL_INDEX,
	output      logic       UPDATE_DONE,
	// Read port into the active, transferred settings.
	input  wire logic       SET_CH,
	input  wire logic [5:0] SET_INDEX,
	output      logic [7:0] SET_DATA
);

	pins_t        sync_first;
	pins_t        sync_pins;
	logic         sclk_prev;
	logic         select_prev;
	logic         sclk_rise;
	logic         sclk_fall;
	logic         select_fall;
	logic         select_rise;
	frame_state_t state;
	logic [3:0]   bit_cnt;
	instr_t       instr;
	instr_t       next_instr;
	logic [2:0]   bytes_left;
	logic [12:0]  addr;
	logic [12:0]  addr_step;
	logic [7:0]   rx_shift;
	logic [7:0]   next_rx;
	logic         streaming;
	logic         instr_done;
	logic         byte_done;
	logic         wr_en;
	logic         soft_rst;
	logic         xfer_pend;
	logic         tx_load;
	logic [7:0]   tx_shift;
	logic [7:0]   read_byte;
	logic         seen_low;
	logic         in_shadow;
	logic [12:0]  shadow_off;
	logic [5:0]   shadow_idx;
	wire  [7:0]   shadow_rd [NUM_CH];
	wire  [7:0]   active_rd [NUM_CH];

	// Two flops on every pin; only the second stage feeds the edge detectors.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			sync_first  <= PINS_IDLE;
			sync_pins   <= PINS_IDLE;
			sclk_prev   <= 1'b0;
			select_prev <= 1'b1;
		end else begin
			sync_first  <= '{sclk: SCLK, select_n: PORT_SELECT_N, sdio: SDIO_IN};
			sync_pins   <= sync_first;
			sclk_prev   <= sync_pins.sclk;
			select_prev <= sync_pins.select_n;
		end
	end

	// Serial clock edges count only while the port is selected.
	assign sclk_rise   = sync_pins.sclk & ~sclk_prev & ~sync_pins.select_n;   // R1 R13
	assign sclk_fall   = ~sync_pins.sclk & sclk_prev & ~sync_pins.select_n;   // R1 R13
	assign select_fall = ~sync_pins.select_n & select_prev;
	assign select_rise = sync_pins.select_n & ~select_prev;

	// Incoming bit assembly; the instruction always arrives first bit on top.
	assign next_instr = instr_t'({instr[14:0], sync_pins.sdio});               // R9
	assign next_rx    = LSB_FIRST ? {sync_pins.sdio, rx_shift[7:1]}
	                              : {rx_shift[6:0], sync_pins.sdio};           // R11
	assign streaming  = {instr.word_length_bit1, instr.word_length_bit0} == WL_STREAM;
	assign instr_done = sclk_rise && (state == ST_INSTR) && (bit_cnt == INSTR_LAST);
	assign byte_done  = sclk_rise && (state == ST_DATA) && (bit_cnt == BYTE_LAST);
	assign wr_en      = byte_done && !instr.read;

	// Address runs downward in most-first order and upward in least-first order.
	assign addr_step = LSB_FIRST ? addr + ADDR_STEP : addr - ADDR_STEP;

	// Frame sequencing: instruction, data words, stall and completion.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state      <= ST_IDLE;
			bit_cnt    <= CNT_START;
			instr      <= '0;
			bytes_left <= 3'h0;
			addr       <= 13'h0000;
			rx_shift   <= BYTE_ZERO;
		end else if (select_rise) begin
			// A stall is only possible cleanly between bytes of a counted transfer.
			if (state == ST_DATA && bit_cnt == CNT_START && !streaming && bytes_left != 3'h0) begin
				state <= ST_STALL;                                             // R4
			end else begin
				state <= ST_IDLE;                                              // R1
			end
		end else if (select_fall) begin
			if (state == ST_STALL) begin
				state <= ST_DATA;                                              // R4
			end else begin
				state   <= ST_INSTR;                                           // R2
				bit_cnt <= CNT_START;                                          // R2
			end
		end else if (sclk_rise) begin
			unique case (state)
				ST_INSTR: begin
					instr   <= next_instr;                                     // R18
					bit_cnt <= bit_cnt + CNT_STEP;
					if (bit_cnt == INSTR_LAST) begin                           // R6
						state      <= ST_DATA;
						bit_cnt    <= CNT_START;
						bytes_left <= {1'b0, next_instr.word_length_bit1, next_instr.word_length_bit0}
						              + BYTES_ONE;                             // R7
						addr       <= next_instr.addr;
					end
				end
				ST_DATA: begin
					rx_shift <= next_rx;                                       // R18
					bit_cnt  <= bit_cnt + CNT_STEP;
					if (bit_cnt == BYTE_LAST) begin                            // R8
						bit_cnt <= CNT_START;
						addr    <= addr_step;
						if (!streaming) begin
							bytes_left <= bytes_left - BYTES_ONE;
							if (bytes_left == BYTES_ONE) begin
								state <= ST_DONE;                              // R7
							end
						end                                                    // R3
					end
				end
				ST_IDLE, ST_STALL, ST_DONE: begin
					// Extra clocks after a completed frame are ignored.
				end
			endcase
		end
	end

	// Port configuration, channel index and transfer command.
	always_ff @(posedge CLK_SYS) begin
		if (RESET || soft_rst) begin
			LSB_FIRST     <= 1'b0;                                             // R11
			CHANNEL_INDEX <= CH_INDEX_RESET;
			soft_rst      <= 1'b0;
			xfer_pend     <= 1'b0;
		end else begin
			// The pending transfer lasts one cycle; a new set always wins over the clear.
			xfer_pend <= 1'b0;                                                 // R16
			if (wr_en) begin
				unique case (addr)
					ADDR_PORT_CFG: begin
						LSB_FIRST <= next_rx[CFG_LSB_HI] | next_rx[CFG_LSB_LO]; // R11
						soft_rst  <= next_rx[CFG_RST_HI] | next_rx[CFG_RST_LO];
					end
					ADDR_CH_INDEX: CHANNEL_INDEX <= next_rx[1:0];
					ADDR_TRANSFER: xfer_pend <= (next_rx == TRANSFER_GO);       // R15
					default: begin
					end
				endcase
			end
		end
	end

	// Update notice rises on the same clock edge as the copy.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			UPDATE_DONE <= 1'b0;
		end else begin
			UPDATE_DONE <= xfer_pend;                                          // R16
		end
	end

	// Shadow window decode for the frame's current address.
	assign in_shadow  = (addr >= ADDR_SHADOW_FIRST) && (addr <= ADDR_SHADOW_LAST);
	assign shadow_off = addr - ADDR_SHADOW_FIRST;
	assign shadow_idx = shadow_off[5:0];

	// Per-channel shadow and active copies; operation only sees the active copy.
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		logic [7:0] shadow [SHADOW_DEPTH];
		logic [7:0] active [SHADOW_DEPTH];

		always_ff @(posedge CLK_SYS) begin
			if (RESET || soft_rst) begin
				for (int i = 0; i < SHADOW_DEPTH; i++) begin
					shadow[i] <= SHADOW_RESET;
					active[i] <= SHADOW_RESET;
				end
			end else begin
				if (wr_en && in_shadow && CHANNEL_INDEX[ch]) begin
					shadow[shadow_idx] <= next_rx;                             // R17
				end
				if (xfer_pend) begin
					active <= shadow;                                          // R15
				end
			end
		end

		assign shadow_rd[ch] = in_shadow ? shadow[shadow_idx] : BYTE_ZERO;
		assign active_rd[ch] = (SET_INDEX <= SHADOW_LAST_IDX) ? active[SET_INDEX] : BYTE_ZERO;
	end

	// Readback value of the current address; unmapped bytes read as zero.
	always_comb begin
		read_byte = BYTE_ZERO;
		if (in_shadow) begin
			read_byte = CHANNEL_INDEX[CH_A_BIT] ? shadow_rd[0] : shadow_rd[1]; // R17
		end else begin
			unique case (addr)
				ADDR_PORT_CFG:   read_byte = PORT_CFG_FIXED | (LSB_FIRST ? CFG_LSB_MASK : BYTE_ZERO);
				ADDR_CHIP_ID:    read_byte = CHIP_ID_VALUE;
				ADDR_CHIP_GRADE: read_byte = {2'h0, SPEED_GRADE, 4'h0};
				ADDR_CH_INDEX:   read_byte = {6'h00, CHANNEL_INDEX};
				ADDR_TRANSFER:   read_byte = {7'h00, xfer_pend};
				default:         read_byte = BYTE_ZERO;
			endcase
		end
	end

	// Load one cycle after the address settles, well before the next falling serial edge.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tx_load <= 1'b0;
		end else begin
			tx_load <= (instr_done && next_instr.read) || (byte_done && instr.read);
		end
	end

	// Readback shifter: bits change on falling edges so the host takes them on rising ones.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tx_shift <= BYTE_ZERO;
			SDIO_OUT <= 1'b0;
		end else if (tx_load) begin
			tx_shift <= read_byte;
		end else if (sclk_fall && state == ST_DATA && instr.read) begin
			SDIO_OUT <= LSB_FIRST ? tx_shift[0] : tx_shift[7];                 // R18 R11
			tx_shift <= LSB_FIRST ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
		end
	end

	// Pin direction; the turnaround waits for the last instruction bit to be taken.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SDIO_OE_N <= 1'b1;
		end else begin
			SDIO_OE_N <= !(state == ST_DATA && instr.read && !sync_pins.select_n); // R10 R12
		end
	end

	// A select that never went low since reset means the pins serve their other function.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			seen_low    <= 1'b0;
			PORT_ALT_EN <= 1'b0;
		end else begin
			if (!sync_pins.select_n) begin
				seen_low <= 1'b1;
			end
			PORT_ALT_EN <= !seen_low && sync_pins.select_n;                    // R5
		end
	end

	// Active settings are presented through a registered read port.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SET_DATA <= BYTE_ZERO;
		end else begin
			SET_DATA <= SET_CH ? active_rd[1] : active_rd[0];
		end
	end

endmodule : adc_config_serial_port

// file: tb/adc_cfg_port_monitor.sv
// Concurrent checks on the configuration port pins and status outputs.
// Assumes serial half periods of at least four system clocks.
`timescale 1ns/100ps
module adc_cfg_port_monitor (
	// Clock and reset.
	input wire logic       CLK_SYS,
	input wire logic       RESET,
	// Serial pins and status.
	input wire logic       SCLK,
	input wire logic       PORT_SELECT_N,
	input wire logic       SDIO_OUT,
	input wire logic       SDIO_OE_N,
	input wire logic       PORT_ALT_EN,
	input wire logic       LSB_FIRST,
	input wire logic [1:0] CHANNEL_INDEX,
	input wire logic       UPDATE_DONE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Select going high must release the shared data pin within the synchroniser delay.
	chk_oe_release: assert property ($rose(PORT_SELECT_N) |-> ##[1:6] SDIO_OE_N)
		else $error("data pin still driven after select rose");
	chk_alt_quiet: assert property (PORT_ALT_EN |-> SDIO_OE_N)
		else $error("data pin driven in alternate mode");
	chk_alt_drop: assert property ($fell(PORT_SELECT_N) |-> ##[1:6] !PORT_ALT_EN)
		else $error("alternate mode kept after select went low");
	// The device drives only inside a selected frame, allowing for the synchroniser.
	chk_drive_sel: assert property (!SDIO_OE_N |-> !PORT_ALT_EN && (!PORT_SELECT_N || !$past(PORT_SELECT_N, 5)))
		else $error("data pin driven outside a frame");
	// Readback bits move only while the serial clock is low, so the host sees them settled.
	chk_out_timing: assert property (!SDIO_OE_N && $past(!SDIO_OE_N) && $changed(SDIO_OUT) |-> !SCLK)
		else $error("readback bit changed while serial clock high");
	chk_done_pulse: assert property (UPDATE_DONE |-> !$past(PORT_SELECT_N, 4) ##1 !UPDATE_DONE)
		else $error("update pulse without a frame or longer than one cycle");
	chk_lsb_hold: assert property ($changed(LSB_FIRST) |-> !$past(PORT_SELECT_N, 3))
		else $error("bit order changed outside a frame");
	chk_idx_hold: assert property ($changed(CHANNEL_INDEX) |-> !$past(PORT_SELECT_N, 3))
		else $error("channel index changed outside a frame");
endmodule : adc_cfg_port_monitor
bind adc_config_serial_port adc_cfg_port_monitor adc_cfg_port_monitor_inst (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.SCLK(SCLK), .PORT_SELECT_N(PORT_SELECT_N), .SDIO_OUT(SDIO_OUT), .SDIO_OE_N(SDIO_OE_N),
	.PORT_ALT_EN(PORT_ALT_EN), .LSB_FIRST(LSB_FIRST), .CHANNEL_INDEX(CHANNEL_INDEX), .UPDATE_DONE(UPDATE_DONE));

// file: tb/adc_config_serial_port_bench.sv
// Self-checking bench for the converter configuration serial port.
// Assumes the host model paces frames and reports every byte read back.
`timescale 1ns/100ps
module adc_config_serial_port_bench;
	import adc_cfg_pkg::*;
	localparam logic [7:0] ID = 8'h5A; // Arbitrary identification value.
	logic        clk_sys, reset, set_ch, sclk, select_n, pin, dev_bit, dev_oe_n, alt_en, lsb_first, done, rd_valid, s;
	logic [5:0]  set_index;
	logic [1:0]  ch_index;
	logic [7:0]  set_data, rd_byte, exp_q[$];
	logic [31:0] r;
	int          n_fail = 0;
	int          checked = 0;
	int          n_done = 0;
	adc_config_serial_port #(.CHIP_ID_VALUE(ID), .SPEED_GRADE(2'h0)) adc_config_serial_port_inst (
		.CLK_SYS(clk_sys), .RESET(reset), .SCLK(sclk), .PORT_SELECT_N(select_n), .SDIO_IN(pin),
		.SDIO_OUT(dev_bit), .SDIO_OE_N(dev_oe_n), .PORT_ALT_EN(alt_en), .LSB_FIRST(lsb_first),
		.CHANNEL_INDEX(ch_index), .UPDATE_DONE(done), .SET_CH(set_ch), .SET_INDEX(set_index),
		.SET_DATA(set_data));
	cfg_host_model cfg_host_model_inst (.clk(clk_sys), .dev_bit(dev_bit), .dev_oe_n(dev_oe_n), .sclk(sclk),
		.select_n(select_n), .pin(pin), .rd_valid(rd_valid), .rd_byte(rd_byte));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// Each byte read back is matched to the oldest expectation; an unexpected byte meets X and fails.
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1)
			check("readback", rd_byte, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
	end
	// Every update notice is counted; each transfer command must give exactly one.
	always @(posedge clk_sys) begin
		if (done === 1'b1)
			n_done++;
	end
	task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
		cfg_host_model_inst.frame(1'b0, 2'h0, a, 1, {24'h000000, d}, lsb, 9);
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic [1:0] wl, input logic [31:0] e, input logic lsb, input int st);
		for (int i = 0; i <= int'(wl); i++) exp_q.push_back(e[8 * i +: 8]);
		cfg_host_model_inst.frame(1'b1, wl, a, int'(wl) + 1, 32'h00000000, lsb, st);
	endtask : rd
	// Active settings are looked at through the side read port, one cycle of latency plus margin.
	task automatic view(input logic ch, input logic [5:0] idx, input logic [7:0] e);
		set_ch <= ch;
		set_index <= idx;
		cfg_host_model_inst.cyc(3);
		check("active value", set_data, e);
	endtask : view
	initial begin
		#3000000;
		n_fail++;
		stop_test();
	end
	initial begin
		reset = 1'b1;
		set_ch = 1'b0;
		set_index = 6'h00;
		r = $urandom(32'h9D6D06DA);
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		cfg_host_model_inst.cyc(6);
		check("alt enable", 8'(alt_en), 8'h01);
		check("pin released", 8'(dev_oe_n), 8'h01);
		check("bit order", 8'(lsb_first), 8'h00);
		check("channel index", 8'(ch_index), 8'h03);
		r = $urandom();
		// Clock edges with select high must change nothing.
		for (int i = 0; i < 8; i++) cfg_host_model_inst.shift(r[i], 1'b1, s);
		check("alt enable idle", 8'(alt_en), 8'h01);
		check("channel index idle", 8'(ch_index), 8'h03);
		wr(ADDR_CH_INDEX, 8'h01, 1'b0);
		check("channel index", 8'(ch_index), 8'h01);
		check("alt enable used", 8'(alt_en), 8'h00);
		// Five streamed bytes from 0x0C down reach 0x08 only if the stream outlasts any counted length.
		cfg_host_model_inst.frame(1'b0, WL_STREAM, 13'h000C, 5, r, 1'b0, 9);
		// A one-byte write followed by a surplus byte must leave 0x0C alone.
		cfg_host_model_inst.frame(1'b0, 2'h0, 13'h000D, 2, ~r, 1'b0, 9);
		view(1'b0, 6'h02, 8'h00);
		wr(ADDR_TRANSFER, TRANSFER_GO, 1'b0);
		view(1'b0, 6'h02, r[23:16]);
		view(1'b0, 6'h00, r[7:0]);
		view(1'b0, 6'h04, r[7:0]);
		view(1'b0, 6'h05, ~r[7:0]);
		view(1'b1, 6'h02, 8'h00);
		rd(ADDR_TRANSFER, 2'h0, 32'h00000000, 1'b0, 9);
		rd(13'h000A, 2'h2, {8'h00, r[7:0], r[31:24], r[23:16]}, 1'b0, 1);
		rd(ADDR_CHIP_ID, 2'h0, {24'h000000, ID}, 1'b0, 9);
		rd(ADDR_PORT_CFG, 2'h0, {24'h000000, PORT_CFG_FIXED}, 1'b0, 9);
		wr(ADDR_PORT_CFG, CFG_LSB_MASK, 1'b0);
		check("bit order", 8'(lsb_first), 8'h01);
		rd(ADDR_CHIP_ID, 2'h1, {16'h0000, 8'h00, ID}, 1'b1, 9);
		wr(ADDR_PORT_CFG, 8'h00, 1'b1);
		check("bit order", 8'(lsb_first), 8'h00);
		wr(ADDR_CH_INDEX, 8'h03, 1'b0);
		wr(ADDR_SHADOW_FIRST, r[31:24], 1'b0);
		wr(ADDR_TRANSFER, TRANSFER_GO, 1'b0);
		view(1'b0, 6'h00, r[31:24]);
		view(1'b1, 6'h00, r[31:24]);
		rd(ADDR_SHADOW_FIRST, 2'h0, {24'h000000, r[31:24]}, 1'b0, 9);
		// Soft reset sent least first: bit order, channel index and settings fall back to defaults.
		wr(ADDR_CH_INDEX, 8'h01, 1'b0);
		wr(ADDR_PORT_CFG, CFG_LSB_MASK, 1'b0);
		wr(ADDR_PORT_CFG, 8'h66, 1'b1);
		check("bit order soft", 8'(lsb_first), 8'h00);
		check("channel index soft", 8'(ch_index), 8'h03);
		view(1'b0, 6'h00, 8'h00);
		check("update pulses", 8'(n_done), 8'h02);
		check("left over", 8'(exp_q.size()), 8'h00);
		stop_test();
	end
endmodule : adc_config_serial_port_bench

// file: tb/cfg_host_model.sv
// Behavioural serial host that frames instructions and data bytes on the three-wire port.
// Assumes the bench calls its tasks and the system clock paces every pin change.
`timescale 1ns/100ps
module cfg_host_model (
	// Pacing clock and the device side of the data pin.
	input  wire logic       clk,
	input  wire logic       dev_bit,
	input  wire logic       dev_oe_n,
	// Pins driven by the host.
	output      logic       sclk,
	output      logic       select_n,
	output      logic       pin,
	// One pulse for each byte read back.
	output      logic       rd_valid,
	output      logic [7:0] rd_byte
);
	logic host_oe = 1'b0;
	logic host_bit = 1'b0;
	logic last = 1'b0;
	// Serial clock idles low and stands still between frames.
	initial begin
		sclk = 1'b0;
		select_n = 1'b1;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
	end
	// A released pin has no keeper, so it shows the inverse of its last level.
	always_comb pin = !dev_oe_n ? dev_bit : (host_oe ? host_bit : ~last);
	always_ff @(posedge clk) last <= pin;
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	// One bit: set up while low, sample on the rising edge, then fall.
	task automatic shift(input logic b, input logic drive, output logic s);
		host_oe <= drive;
		host_bit <= b;
		cyc(4);
		sclk <= 1'b1;
		s = pin;
		cyc(4);
		sclk <= 1'b0;
	endtask : shift
	// Whole frame; stall raises select before the given byte and resumes without an instruction.
	// Bytes past the fourth repeat the data word, so a stream can outlast any counted length.
	task automatic frame(input logic rd, input logic [1:0] wl, input logic [12:0] addr, input int n,
		input logic [31:0] data, input logic lsb, input int stall);
		logic [15:0] ins;
		logic [7:0]  got;
		logic        s;
		ins = {rd, wl, addr};
		select_n <= 1'b0;
		cyc(4);
		for (int i = 15; i >= 0; i--) shift(ins[i], 1'b1, s);
		for (int k = 0; k < n; k++) begin
			if (k == stall) begin
				select_n <= 1'b1;
				cyc(8);
				select_n <= 1'b0;
				cyc(4);
			end
			for (int j = 0; j < 8; j++) begin
				shift(data[8 * (k % 4) + (lsb ? j : 7 - j)], !rd, s);
				got[lsb ? j : 7 - j] = s;
			end
			if (rd) begin
				rd_byte <= got;
				rd_valid <= 1'b1;
				cyc(1);
				rd_valid <= 1'b0;
			end
		end
		host_oe <= 1'b0;
		cyc(4);
		select_n <= 1'b1;
		cyc(8);
	endtask : frame
endmodule : cfg_host_model
